// *** scpl_cmd_if.sv ***
// Command carrier between the link controller and each line engine
`timescale 1ns/1ps
interface scpl_cmd_if;
    logic enable;
    logic send;
    logic [5:0] code;
    logic busy;
    logic active;
    logic line;
    modport ctrl (output enable, output send, output code, input busy, input active, input line);
    modport eng (input enable, input send, input code, output busy, output active, output line);
endinterface

// *** scpl_line.sv ***
// One link line engine: start, pulse trains, stop and off intervals
`timescale 1ns/1ps
module scpl_line import scpl_pkg::*; #(
    parameter int T_WAIT = 200,
    parameter int T_LOW = 100,
    parameter int T_HIGH = 100,
    parameter int T_STOP = 400,
    parameter int T_OFF = 800
) (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Sync reset, active low
    scpl_cmd_if.eng cmd // Command carrier
);
    scpl_state_e state;
    logic [15:0] tmr;
    logic [6:0] left;

    assign cmd.busy = (state != SCPL_READY);
    assign cmd.active = (state != SCPL_IDLE);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= SCPL_IDLE;
            tmr <= 16'h0000;
            left <= 7'h00;
            cmd.line <= 1'b0;
        end else begin
            if (tmr != 16'h0000) begin
                tmr <= tmr - 16'h0001;
            end
            case (state)
                SCPL_IDLE: begin
                    cmd.line <= 1'b0;
                    if (cmd.enable) begin
                        cmd.line <= 1'b1; // [RULE1]
                        tmr <= 16'(T_WAIT - 1);
                        state <= SCPL_WAIT;
                    end
                end
                SCPL_WAIT: begin
                    if (!cmd.enable) begin
                        cmd.line <= 1'b0;
                        tmr <= 16'(T_OFF - 1);
                        state <= SCPL_OFF;
                    end else if (tmr == 16'h0000) begin
                        state <= SCPL_READY; // [RULE1]
                    end
                end
                SCPL_READY: begin
                    if (!cmd.enable) begin
                        cmd.line <= 1'b0; // [RULE5]
                        tmr <= 16'(T_OFF - 1);
                        state <= SCPL_OFF;
                    end else if (cmd.send) begin
                        left <= {1'b0, cmd.code} + 7'h01; // [RULE7]
                        cmd.line <= 1'b0; // [RULE2]
                        tmr <= 16'(T_LOW - 1);
                        state <= SCPL_LOW; // [RULE4]
                    end
                end
                SCPL_LOW: begin
                    if (tmr == 16'h0000) begin
                        cmd.line <= 1'b1; // [RULE2]
                        left <= left - 7'h01;
                        tmr <= 16'(T_HIGH - 1);
                        state <= SCPL_HIGH;
                    end
                end
                SCPL_HIGH: begin
                    if (tmr == 16'h0000) begin
                        if (left != 7'h00) begin
                            cmd.line <= 1'b0;
                            tmr <= 16'(T_LOW - 1);
                            state <= SCPL_LOW;
                        end else begin
                            tmr <= 16'(T_STOP - 1); // [RULE3]
                            state <= SCPL_STOP;
                        end
                    end
                end
                SCPL_STOP: begin
                    if (tmr == 16'h0000) begin
                        state <= SCPL_READY; // [RULE3]
                    end
                end
                SCPL_OFF: begin
                    cmd.line <= 1'b0;
                    if (tmr == 16'h0000) begin
                        state <= SCPL_IDLE; // [RULE5]
                    end
                end
                default: state <= SCPL_IDLE;
            endcase
        end
    end
endmodule

// *** scpl_map.svh ***
// Register map, field positions, reset values and timing counts of the slave link block
// Summary of operation
// [RULE1] A transmission starts by raising the link line, and commands wait out the start interval.
// [RULE2] A command is a train of low-then-high pulses, counted by the slave on rising edges.
// [RULE3] After the last pulse the line stays high for the stop interval to close the command.
// [RULE4] Further commands, each with its own stop interval, may follow once the start wait ends.
// [RULE5] Holding the line low for the off delay ends the transmission and turns the slave off.
// [RULE6] There are two link lines, and their start-up is staggered so slaves never start together.
// [RULE7] The slave current is one of 64 levels of 25 mA, sent as the pulse count.
// [RULE8] The slave applies a new current only after the stop interval has elapsed.
// [RULE9] Slaves stay enabled only while the main charger is in its CC or CV phase.
// [RULE10] By default the sent current is the lesser of the slave setting and the master limit.
// [RULE11] With the bypass set, the slave setting is sent unchanged.
// [RULE12] Slave faults set flags at 0x80 bits 0, 1 and 2, with mask bits at 0x81.
// [RULE13] Unmasked slave faults show as bit 6 of the source register 0x22, masked at 0x23.
// [RULE14] A strap at ground means internal sensing and no slaves; at the rail, slaves are allowed.
// [RULE15] The start, pulse low, pulse high, stop and off durations are counter parameters.
`ifndef SCPL_MAP_SVH
`define SCPL_MAP_SVH

`define SCPL_ADDR_TOP_SRC 8'h22
`define SCPL_ADDR_TOP_MASK 8'h23
`define SCPL_ADDR_FLT_FLAGS 8'h80
`define SCPL_ADDR_FLT_MASK 8'h81
`define SCPL_RST_TOP_MASK 8'hFF
`define SCPL_RST_FLT_MASK 8'hFF
`define SCPL_BIT_TOP_SLAVE 6
`define SCPL_BIT_FLT_S1 0
`define SCPL_BIT_FLT_S2 1
`define SCPL_BIT_FLT_CV 2
`define SCPL_STEPS 64
`define SCPL_STEP_MA 25
`define SCPL_CLK_MHZ 200
`define SCPL_T_WAIT_NS 1000
`define SCPL_T_LOW_NS 500
`define SCPL_T_HIGH_NS 500
`define SCPL_T_STOP_NS 2000
`define SCPL_T_OFF_NS 4000
`define SCPL_T_STAGGER_NS 8000
`define SCPL_NS_TO_CYC(t) (((t) * `SCPL_CLK_MHZ + 999) / 1000)

`endif

// *** scpl_pkg.sv ***
// Types shared by the slave link block
package scpl_pkg;
    typedef enum logic [2:0] {
        SCPL_IDLE,
        SCPL_WAIT,
        SCPL_LOW,
        SCPL_HIGH,
        SCPL_STOP,
        SCPL_READY,
        SCPL_OFF
    } scpl_state_e;
    typedef logic [5:0] scpl_code_t;
endpackage

// *** scpl_slave_model.sv ***
// Behavioural slave charger listening on one link line
`timescale 1ns/1ps
module scpl_slave_model #(
    parameter int T_STOP = 5,
    parameter int T_OFF = 6
) (
    input wire logic clk_in, // Clock
    input wire logic line_in, // Link line
    output logic on_out, // Charger running
    output logic [5:0] code_out // Applied current code
);
    int hi = 0;
    int lo = 0;
    int edges = 0;
    logic prev = 1'b0;
    initial on_out = 1'b0;
    initial code_out = 6'h00;
    always @(posedge clk_in) begin
        if (line_in && !prev) begin
            if (on_out) edges++;
            on_out <= 1'b1;
        end
        hi = line_in ? hi + 1 : 0;
        lo = line_in ? 0 : lo + 1;
        if (hi == T_STOP && edges > 0) begin
            code_out <= 6'(edges - 1);
            edges = 0;
        end
        if (lo == T_OFF) begin
            on_out <= 1'b0;
            edges = 0;
        end
        prev = line_in;
    end
endmodule

// *** scpl_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scpl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic [WIDTH-1:0] d_in, // Asynchronous input
    output logic [WIDTH-1:0] q_out // Synchronised output
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// *** scpl_top.sv ***
// Slave charger link controller: current selection, two staggered lines, fault registers
`timescale 1ns/1ps
`include "scpl_map.svh"
module scpl_top import scpl_pkg::*; #(
    parameter int T_WAIT = `SCPL_NS_TO_CYC(`SCPL_T_WAIT_NS),
    parameter int T_LOW = `SCPL_NS_TO_CYC(`SCPL_T_LOW_NS),
    parameter int T_HIGH = `SCPL_NS_TO_CYC(`SCPL_T_HIGH_NS),
    parameter int T_STOP = `SCPL_NS_TO_CYC(`SCPL_T_STOP_NS),
    parameter int T_OFF = `SCPL_NS_TO_CYC(`SCPL_T_OFF_NS),
    parameter int T_STAGGER = `SCPL_NS_TO_CYC(`SCPL_T_STAGGER_NS)
) (
    input wire logic clk_in, // Clock 200 MHz
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic cc_cv_phase_in, // Main charger in CC or CV phase
    input wire logic sense_strap_in, // Strap pin, high = external sense
    input wire logic [5:0] slave_current_setting_in, // Programmed slave current code
    input wire logic [5:0] master_charge_limit_in, // Master limit in slave steps
    input wire logic min_compare_bypass_in, // Send setting unchanged
    input wire logic first_follower_fault_in, // Fault pin from slave 1
    input wire logic second_follower_fault_in, // Fault pin from slave 2
    input wire logic voltage_phase_fault_in, // Fault from CV source
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    input wire logic [7:0] reg_addr_in, // Register address
    input wire logic [7:0] reg_wdata_in, // Register write data
    output logic [7:0] reg_rdata_out, // Register read data
    output logic slave_link_line_1_out, // Link line to slave 1
    output logic slave_link_line_2_out, // Link line to slave 2
    output logic ext_sense_out, // External sense selected
    output logic slave_irq_out // Unmasked slave fault pending
);
    scpl_cmd_if c1 ();
    scpl_cmd_if c2 ();

    logic [3:0] pins_s;
    logic strap_s;
    logic [2:0] flt_s;
    logic [2:0] flt_d;
    logic [2:0] flt_rise;
    logic [7:0] flt_flags;
    logic [7:0] flt_mask;
    logic [7:0] top_mask;
    logic [7:0] top_src;
    logic [15:0] stag;
    logic allow;
    logic [5:0] next_code;
    logic [5:0] sent1;
    logic [5:0] sent2;
    logic v1;
    logic v2;

    ////////////////////////////////////////////////////////////////////////////////
    scpl_sync #(.WIDTH(4)) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in({sense_strap_in, voltage_phase_fault_in, second_follower_fault_in,
               first_follower_fault_in}),
        .q_out(pins_s)
    );
    assign strap_s = pins_s[3];
    assign flt_s = pins_s[2:0];
    assign ext_sense_out = strap_s; // [RULE14]

    ////////////////////////////////////////////////////////////////////////////////
    // Current to send
    always_comb begin
        if (min_compare_bypass_in) begin
            next_code = slave_current_setting_in; // [RULE11]
        end else if (master_charge_limit_in < slave_current_setting_in) begin
            next_code = master_charge_limit_in; // [RULE10]
        end else begin
            next_code = slave_current_setting_in; // [RULE10]
        end
    end

    assign allow = cc_cv_phase_in && strap_s; // [RULE9] [RULE14]

    ////////////////////////////////////////////////////////////////////////////////
    // Stagger: line 2 enables only after line 1 has been up for T_STAGGER
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stag <= 16'h0000;
        end else if (!allow || !c1.active) begin
            stag <= 16'h0000;
        end else if (stag != 16'(T_STAGGER)) begin
            stag <= stag + 16'h0001; // [RULE6]
        end
    end

    assign c1.enable = allow;
    assign c2.enable = allow && (stag == 16'(T_STAGGER)); // [RULE6]
    assign c1.code = next_code;
    assign c2.code = next_code;
    // Resend whenever the current differs from what a line last carried
    assign c1.send = !c1.busy && (!v1 || sent1 != next_code);
    assign c2.send = !c2.busy && (!v2 || sent2 != next_code);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sent1 <= 6'h00;
            sent2 <= 6'h00;
            v1 <= 1'b0;
            v2 <= 1'b0;
        end else begin
            if (!c1.active) begin
                v1 <= 1'b0;
            end else if (c1.send) begin
                sent1 <= next_code; // [RULE4]
                v1 <= 1'b1;
            end
            if (!c2.active) begin
                v2 <= 1'b0;
            end else if (c2.send) begin
                sent2 <= next_code; // [RULE4]
                v2 <= 1'b1;
            end
        end
    end

    scpl_line #(.T_WAIT(T_WAIT), .T_LOW(T_LOW), .T_HIGH(T_HIGH), .T_STOP(T_STOP),
                .T_OFF(T_OFF)) u_line1 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .cmd(c1)
    ); // [RULE15]
    scpl_line #(.T_WAIT(T_WAIT), .T_LOW(T_LOW), .T_HIGH(T_HIGH), .T_STOP(T_STOP),
                .T_OFF(T_OFF)) u_line2 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .cmd(c2)
    );
    assign slave_link_line_1_out = c1.line;
    assign slave_link_line_2_out = c2.line;

    ////////////////////////////////////////////////////////////////////////////////
    // Fault flags: set on a rising fault, cleared on read, set wins
    assign flt_rise = flt_s & ~flt_d;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flt_d <= 3'h0;
            flt_flags <= 8'h00;
        end else begin
            flt_d <= flt_s;
            if (reg_rd_in && reg_addr_in == `SCPL_ADDR_FLT_FLAGS) begin
                flt_flags <= {5'h00, flt_rise}; // [RULE12]
            end else begin
                flt_flags <= flt_flags | {5'h00, flt_rise}; // [RULE12]
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flt_mask <= `SCPL_RST_FLT_MASK;
            top_mask <= `SCPL_RST_TOP_MASK;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `SCPL_ADDR_FLT_MASK) begin
                flt_mask <= reg_wdata_in;
            end else if (reg_addr_in == `SCPL_ADDR_TOP_MASK) begin
                top_mask <= reg_wdata_in; // [RULE13]
            end
        end
    end

    always_comb begin
        top_src = 8'h00;
        top_src[`SCPL_BIT_TOP_SLAVE] = |(flt_flags[2:0] & ~flt_mask[2:0]); // [RULE13]
    end
    assign slave_irq_out = top_src[`SCPL_BIT_TOP_SLAVE] & ~top_mask[`SCPL_BIT_TOP_SLAVE];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_addr_in == `SCPL_ADDR_TOP_SRC) begin
                reg_rdata_out <= top_src;
            end else if (reg_addr_in == `SCPL_ADDR_TOP_MASK) begin
                reg_rdata_out <= top_mask;
            end else if (reg_addr_in == `SCPL_ADDR_FLT_FLAGS) begin
                reg_rdata_out <= flt_flags;
            end else if (reg_addr_in == `SCPL_ADDR_FLT_MASK) begin
                reg_rdata_out <= flt_mask;
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end
endmodule

// *** scpl_top_asserts.sv ***
// Port checker for the slave link block
`timescale 1ns/1ps
module scpl_top_chk (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Sync reset, active low
    input wire logic reg_rd_in, // Read strobe
    input wire logic [7:0] reg_addr_in, // Register address
    input wire logic [7:0] reg_rdata_out, // Read data
    input wire logic slave_link_line_1_out, // Line to slave 1
    input wire logic slave_link_line_2_out, // Line to slave 2
    input wire logic slave_irq_out // Fault interrupt
);
    wire l1 = slave_link_line_1_out;
    wire l2 = slave_link_line_2_out;
    logic [3:0] lo_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Length of the current low run on line 1, saturating
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || l1)
            lo_cnt <= 4'h0;
        else if (lo_cnt != 4'hF)
            lo_cnt <= lo_cnt + 4'h1;
    end
    property p_start_wait;
        $rose(l1) && lo_cnt > 4'h3 |-> l1 [*4];
    endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("line 1 start level too short");
    property p_pulse_low;
        $fell(l1) |-> !l1 [*2];
    endproperty
    a_pulse_low: assert property (p_pulse_low)
        else $error("line 1 low phase too short");
    property p_off_hold;
        $fell(l1) ##1 !l1 ##1 !l1 |=> !l1 [*3];
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("line 1 off interval too short");
    property p_stagger;
        $rose(l2) |-> lo_cnt < 4'h4;
    endproperty
    a_stagger: assert property (p_stagger)
        else $error("line 2 active while line 1 idle");
    property p_irq_src;
        reg_rd_in && reg_addr_in == 8'h22 && slave_irq_out |=> reg_rdata_out[6];
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("interrupt without source bit");
    property p_src_bits;
        reg_rd_in && reg_addr_in == 8'h22 |=> (reg_rdata_out & 8'hBF) == 8'h00;
    endproperty
    a_src_bits: assert property (p_src_bits)
        else $error("stray bit in source register");
    property p_flag_bits;
        reg_rd_in && reg_addr_in == 8'h80 |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_flag_bits: assert property (p_flag_bits)
        else $error("stray bit in fault flags");
    property p_unmapped;
        reg_rd_in && !(reg_addr_in inside {8'h22, 8'h23, 8'h80, 8'h81})
            |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    c_line2: cover property ($rose(l2));
    c_irq: cover property (slave_irq_out);
    c_clear: cover property (reg_rd_in && reg_addr_in == 8'h80 && slave_irq_out);
endmodule
bind scpl_top scpl_top_chk u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_rdata_out(reg_rdata_out),
    .slave_link_line_1_out(slave_link_line_1_out),
    .slave_link_line_2_out(slave_link_line_2_out),
    .slave_irq_out(slave_irq_out)
);

// *** scpl_top_tb_top.sv ***
// Testbench for the slave link block
`timescale 1ns/1ps
module scpl_top_tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cc = 1'b0, strap = 1'b1, byp = 1'b0, f1 = 1'b0, f2 = 1'b0, fcv = 1'b0;
    logic wr = 1'b0, rd = 1'b0, l1, l2, ext, irq, on1, on2;
    logic [5:0] set = 6'h0A, lim = 6'h28, c1, c2;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [5:0] tset [0:4] = '{6'h0A, 6'h0A, 6'h0A, 6'h3F, 6'h3F};
    logic [5:0] tlim [0:4] = '{6'h28, 6'h03, 6'h03, 6'h00, 6'h00};
    logic tbyp [0:4] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    // Short link timings so the five current cases, up to code 0x3F, fit the cycle budget
    localparam int SIM_WAIT = 4;
    localparam int SIM_LOW = 2;
    localparam int SIM_HIGH = 2;
    localparam int SIM_STOP = 5;
    localparam int SIM_OFF = 6;
    localparam int SIM_STAGGER = 20;
    always #2.5 clk_in = ~clk_in;
    scpl_top #(.T_WAIT(SIM_WAIT), .T_LOW(SIM_LOW), .T_HIGH(SIM_HIGH), .T_STOP(SIM_STOP),
               .T_OFF(SIM_OFF), .T_STAGGER(SIM_STAGGER)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cc_cv_phase_in(cc), .sense_strap_in(strap),
        .slave_current_setting_in(set), .master_charge_limit_in(lim),
        .min_compare_bypass_in(byp), .first_follower_fault_in(f1),
        .second_follower_fault_in(f2), .voltage_phase_fault_in(fcv), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
        .slave_link_line_1_out(l1), .slave_link_line_2_out(l2), .ext_sense_out(ext),
        .slave_irq_out(irq));
    scpl_slave_model #(.T_STOP(SIM_STOP), .T_OFF(SIM_OFF)) s1 (.clk_in(clk_in), .line_in(l1),
        .on_out(on1), .code_out(c1));
    scpl_slave_model #(.T_STOP(SIM_STOP), .T_OFF(SIM_OFF)) s2 (.clk_in(clk_in), .line_in(l2),
        .on_out(on2), .code_out(c2));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task fault(input int i);
        @(posedge clk_in);
        {fcv, f2, f1} <= 3'(1 << i);
        repeat (4) @(posedge clk_in);
        {fcv, f2, f1} <= 3'b000;
        repeat (4) @(posedge clk_in);
    endtask
    task wait_on(input logic [1:0] e);
        int n;
        n = 0;
        while ({on2, on1} !== e && n < 700) begin
            @(posedge clk_in);
            n++;
        end
        #1 chk({6'h00, on2, on1}, {6'h00, e});
    endtask
    task wait_code(input logic [5:0] e);
        int n;
        n = 0;
        while ((c1 !== e || c2 !== e) && n < 700) begin
            @(posedge clk_in);
            n++;
        end
        #1 chk({2'b00, c1}, {2'b00, e});
        chk({2'b00, c2}, {2'b00, e});
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h23, 8'hFF);
        rd_chk(8'h80, 8'h00);
        rd_chk(8'h81, 8'hFF);
        wr_reg(8'h22, 8'h5A);
        wr_reg(8'h80, 8'h07);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h80, 8'h00);
        rd_chk(8'h55, 8'h00);
        wr_reg(8'h81, 8'h00);
        wr_reg(8'h23, 8'h00);
        rd_chk(8'h23, 8'h00);
        for (int i = 0; i < 3; i++) begin
            fault(i);
            chk({7'h00, irq}, 8'h01);
            rd_chk(8'h22, 8'h40);
            rd_chk(8'h80, 8'(1 << i));
            rd_chk(8'h80, 8'h00);
        end
        wr_reg(8'h23, 8'h40);
        fault(1);
        chk({7'h00, irq}, 8'h00);
        rd_chk(8'h22, 8'h40);
        wr_reg(8'h81, 8'h02);
        rd_chk(8'h22, 8'h00);
        rd_chk(8'h80, 8'h02);
        chk({7'h00, ext}, 8'h01);
        @(posedge clk_in);
        cc <= 1'b1;
        wait_on(2'b01);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_in);
            set <= tset[i];
            lim <= tlim[i];
            byp <= tbyp[i];
            wait_code(tbyp[i] ? tset[i] : (tset[i] < tlim[i] ? tset[i] : tlim[i]));
        end
        @(posedge clk_in);
        cc <= 1'b0;
        wait_on(2'b00);
        @(posedge clk_in);
        strap <= 1'b0;
        // Let the strap pass its synchroniser before the charge phase returns
        repeat (4) @(posedge clk_in);
        cc <= 1'b1;
        repeat (40) @(posedge clk_in);
        chk({5'h00, ext, on2, on1}, 8'h00);
        strap <= 1'b1;
        wait_on(2'b01);
        wait_on(2'b11);
        tally_and_finish;
    end
endmodule
